// File: at8tc_pkg.sv
// Shared constants for the 8-bit timer/counter core
package at8tc_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [3:0] REG_CTRL_A   = 4'h0;
	localparam logic [3:0] REG_CTRL_B   = 4'h1;
	localparam logic [3:0] REG_COUNT    = 4'h2;
	localparam logic [3:0] REG_CMP_A    = 4'h3;
	localparam logic [3:0] REG_CMP_B    = 4'h4;
	localparam logic [3:0] REG_IRQ_MASK = 4'h5;
	localparam logic [3:0] REG_IRQ_FLAG = 4'h6;
	localparam logic [3:0] REG_ASYNC    = 4'h7;
	localparam logic [3:0] REG_POWER    = 4'h8;
	// Field positions
	localparam int WGM_LO_POS  = 0;
	localparam int CS_POS      = 0;
	localparam int WGM_HI_POS  = 3;
	localparam int ASYNC_POS   = 0;
	localparam int PWR_POS     = 0;
	localparam int FLAG_OVF    = 0;
	localparam int FLAG_MA     = 1;
	localparam int FLAG_MB     = 2;
	// Reset values
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [2:0] RST_FLAGS = 3'h0;
	localparam logic       RST_PWR   = 1'b0;
	// Count limits
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hff;
	// Clock select codes
	localparam logic [2:0] CS_OFF = 3'h0;
	// Waveform modes
	localparam logic [2:0] WGM_NORMAL  = 3'h0;
	localparam logic [2:0] WGM_PC_MAX  = 3'h1;
	localparam logic [2:0] WGM_CTC     = 3'h2;
	localparam logic [2:0] WGM_FP_MAX  = 3'h3;
	localparam logic [2:0] WGM_PC_OCRA = 3'h5;
	localparam logic [2:0] WGM_FP_OCRA = 3'h7;
	// Prescaler width
	localparam int PRE_W = 10;
endpackage

// File: at8tc_tick_if.sv
// Tick request and tick pulse between the core and its tick generator
`timescale 1ns/1ps
interface at8tc_tick_if;
	logic [2:0] clock_select_field;
	logic       async_clock_select;
	logic       run;
	logic       timer_tick;
	modport core (output clock_select_field, output async_clock_select, output run,
		input timer_tick);
	modport gen  (input clock_select_field, input async_clock_select, input run,
		output timer_tick);
endinterface

// File: at8tc_tick_gen.sv
// Tick generator: source select, oscillator pin sync and prescaler
`timescale 1ns/1ps
module at8tc_tick_gen
	import at8tc_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  sys_rst,
	input  wire logic  osc_pin_in,
	at8tc_tick_if.gen  tk
);
	logic [1:0]       osc_sync_q;
	logic             osc_prev_q;
	logic             src_pulse;
	logic [PRE_W-1:0] pre_q;

	// Divisor mask for each clock select code
	function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] cs);
		case (cs)
			3'h1:    div_mask = 10'h000;
			3'h2:    div_mask = 10'h007;
			3'h3:    div_mask = 10'h01f;
			3'h4:    div_mask = 10'h03f;
			3'h5:    div_mask = 10'h07f;
			3'h6:    div_mask = 10'h0ff;
			default: div_mask = 10'h3ff;
		endcase
	endfunction

	// Two-flop sync of the oscillator pin before edge detection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			osc_sync_q <= 2'h0;
			osc_prev_q <= 1'b0;
		end else begin
			osc_sync_q <= {osc_sync_q[0], osc_pin_in};
			osc_prev_q <= osc_sync_q[1];
		end
	end

	// Source pulse: every io_clock cycle, or each rising oscillator edge
	assign src_pulse = tk.async_clock_select ? (osc_sync_q[1] & ~osc_prev_q) : 1'b1; // RULE_05

	// Prescaler held at zero while run is low (power gate set) so the first tick spacing is full
	always_ff @(posedge clk) begin
		if (sys_rst || !tk.run) begin
			pre_q <= '0;
		end else if (src_pulse) begin
			pre_q <= pre_q + 10'h001;
		end
	end

	assign tk.timer_tick = tk.run && (tk.clock_select_field != CS_OFF) && src_pulse &&
		((pre_q & div_mask(tk.clock_select_field)) == div_mask(tk.clock_select_field)); // RULE_06
endmodule // at8tc_tick_gen

// File: at8tc_core.sv
// 8-bit timer/counter core with Avalon-MM register slave
// Behaviour
// RULE_01 - Count and compare registers are eight bits
// RULE_02 - Software clears power gate before operation
// RULE_03 - Flags visible; each masked by own bit
// RULE_04 - Overflow, match A, match B interrupt sources
// RULE_05 - Tick from io_clock or oscillator pin
// RULE_06 - Clock select zero stops the counter
// RULE_07 - Counter readable and writable at any time
// RULE_08 - Processor write beats clear or count
// RULE_09 - Each tick clears, increments or decrements
// RULE_10 - Step by one; clear forces zero
// RULE_11 - Mode from control A and B bits
// RULE_12 - Overflow flag set per mode condition
// RULE_13 - Compares double-buffered, compared every cycle
// RULE_14 - Compare match sets channel match flag
// RULE_15 - Compare results drive two waveform outputs
// RULE_16 - Bottom signalled when count is zero
// RULE_17 - Max signalled when count is 0xff
// RULE_18 - Top is 0xff or compare A
// RULE_19 - Mode 0 wraps, overflow on zero
// RULE_20 - Mode 2 clears after matching compare A
// RULE_21 - Fast PWM top 0xff or compare A
// RULE_22 - Modes 1 and 5 count up then down
// RULE_23 - Reset clears counter, compares, select, flags
`timescale 1ns/1ps
module at8tc_core
	import at8tc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        osc_pin_in,
	output logic             osc_pin_out,
	output logic             compare_output_a,
	output logic             compare_output_b,
	output logic             irq_request
);
	at8tc_tick_if tk ();

	logic [1:0]  wgm_lo_q;
	logic [2:0]  cs_q;
	logic        wgm_hi_q;
	logic        async_q;
	logic        pwr_gate_q;
	logic [7:0]  counter_value_q;
	logic [7:0]  counter_value_d;
	logic [7:0]  cmp_buf_a_q;
	logic [7:0]  cmp_buf_b_q;
	logic [7:0]  cmp_act_a_q;
	logic [7:0]  cmp_act_b_q;
	logic [2:0]  irq_mask_q;
	logic [2:0]  irq_flag_q;
	logic [2:0]  flag_set;
	logic        dir_down_q;
	logic        ack_q;
	logic [31:0] avs_readdata_q;
	logic        wr_stb;
	logic [2:0]  waveform_mode_field;
	logic        pc_mode;
	logic        fp_mode;
	logic [7:0]  top_value;
	logic        at_top;
	logic        at_bottom;
	logic        at_max;
	logic        match_a;
	logic        match_b;
	logic        clear_cnt;
	logic        dir_down;
	logic        reload_cmp;
	logic        cnt_write;
	logic        out_a_q;
	logic        out_b_q;

	// Byte lane 0 strobe; upper lanes hold nothing
	function automatic logic wr_hit(input logic [3:0] idx, input logic [3:0] addr,
		input logic stb, input logic be0);
		wr_hit = stb && be0 && (addr == idx);
	endfunction

	// One wait state: waitrequest drops in the cycle after the request appears
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign wr_stb          = avs_write && ack_q;
	assign cnt_write       = wr_hit(REG_COUNT, avs_address, wr_stb, avs_byteenable[0]);

	// Mode assembled from two low and one high control bit
	assign waveform_mode_field = {wgm_hi_q, wgm_lo_q}; // RULE_11
	assign pc_mode = (waveform_mode_field == WGM_PC_MAX) || (waveform_mode_field == WGM_PC_OCRA);
	assign fp_mode = (waveform_mode_field == WGM_FP_MAX) || (waveform_mode_field == WGM_FP_OCRA);

	// Top chosen by mode: compare A in modes 2, 5, 7, else max
	assign top_value = ((waveform_mode_field == WGM_CTC) || (waveform_mode_field == WGM_PC_OCRA) ||
		(waveform_mode_field == WGM_FP_OCRA)) ? cmp_act_a_q : CNT_MAX; // RULE_18

	// Condition decodes and continuous compares
	assign at_bottom = (counter_value_q == CNT_BOTTOM); // RULE_16
	assign at_max    = (counter_value_q == CNT_MAX); // RULE_17
	assign at_top    = (counter_value_q == top_value);
	assign match_a   = (counter_value_q == cmp_act_a_q); // RULE_13
	assign match_b   = (counter_value_q == cmp_act_b_q); // RULE_13

	// Clear request: at top in single-slope modes with compare A top
	assign clear_cnt = ((waveform_mode_field == WGM_CTC) && match_a) || // RULE_20
		((waveform_mode_field == WGM_FP_OCRA) && at_top); // RULE_21

	// Direction: dual slope turns at top and bottom; others count up
	assign dir_down = pc_mode && (at_top ? 1'b1 : (at_bottom ? 1'b0 : dir_down_q)); // RULE_22

	// Next count value; the processor write overrides every tick action
	always_comb begin
		counter_value_d = counter_value_q;
		if (cnt_write) begin
			counter_value_d = avs_writedata[7:0]; // RULE_07 RULE_08
		end else if (tk.timer_tick) begin
			if (clear_cnt) begin
				counter_value_d = CNT_BOTTOM; // RULE_10
			end else if (dir_down) begin
				counter_value_d = counter_value_q - 8'h01; // RULE_09 RULE_10
			end else begin
				counter_value_d = counter_value_q + 8'h01; // RULE_09 RULE_19
			end
		end
	end

	// Eight-bit counter storage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			counter_value_q <= RST_BYTE; // RULE_23
		end else begin
			counter_value_q <= counter_value_d; // RULE_01
		end
	end

	// Direction register follows the turn decision on each tick without a counter write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dir_down_q <= 1'b0;
		end else if (!pc_mode) begin
			dir_down_q <= 1'b0;
		end else if (tk.timer_tick && !cnt_write) begin
			dir_down_q <= dir_down; // RULE_22
		end
	end

	// Compare reload: immediate in non-PWM modes, at top in PWM modes to avoid glitches
	assign reload_cmp = !(pc_mode || fp_mode) || (tk.timer_tick && at_top);

	// Written compare values land in the buffer first
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmp_buf_a_q <= RST_BYTE; // RULE_23
			cmp_buf_b_q <= RST_BYTE;
		end else begin
			if (wr_hit(REG_CMP_A, avs_address, wr_stb, avs_byteenable[0])) begin
				cmp_buf_a_q <= avs_writedata[7:0]; // RULE_01
			end
			if (wr_hit(REG_CMP_B, avs_address, wr_stb, avs_byteenable[0])) begin
				cmp_buf_b_q <= avs_writedata[7:0]; // RULE_01
			end
		end
	end

	// Active compare values used by the comparators
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmp_act_a_q <= RST_BYTE;
			cmp_act_b_q <= RST_BYTE;
		end else if (reload_cmp) begin
			cmp_act_a_q <= cmp_buf_a_q; // RULE_13
			cmp_act_b_q <= cmp_buf_b_q; // RULE_13
		end
	end

	// Event sources per mode
	always_comb begin
		flag_set = 3'h0;
		if (tk.timer_tick && !cnt_write) begin
			flag_set[FLAG_MA] = match_a; // RULE_14
			flag_set[FLAG_MB] = match_b; // RULE_14
			if (pc_mode) begin
				flag_set[FLAG_OVF] = at_bottom && dir_down_q; // RULE_12 RULE_22
			end else if (waveform_mode_field == WGM_FP_OCRA) begin
				flag_set[FLAG_OVF] = at_top; // RULE_12 RULE_21
			end else begin
				flag_set[FLAG_OVF] = at_max && !clear_cnt; // RULE_12 RULE_19
			end
		end
	end

	// Sticky flags, write one to clear; a new event wins over a clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_flag_q <= RST_FLAGS; // RULE_23
		end else if (wr_hit(REG_IRQ_FLAG, avs_address, wr_stb, avs_byteenable[0])) begin
			irq_flag_q <= (irq_flag_q & ~avs_writedata[2:0]) | flag_set; // RULE_03 RULE_04
		end else begin
			irq_flag_q <= irq_flag_q | flag_set; // RULE_04
		end
	end

	// Control and mask registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wgm_lo_q   <= 2'h0;
			cs_q       <= CS_OFF; // RULE_23
			wgm_hi_q   <= 1'b0;
			async_q    <= 1'b0;
			pwr_gate_q <= RST_PWR;
			irq_mask_q <= RST_FLAGS; // RULE_23
		end else begin
			if (wr_hit(REG_CTRL_A, avs_address, wr_stb, avs_byteenable[0])) begin
				wgm_lo_q <= avs_writedata[WGM_LO_POS +: 2];
			end
			if (wr_hit(REG_CTRL_B, avs_address, wr_stb, avs_byteenable[0])) begin
				cs_q     <= avs_writedata[CS_POS +: 3];
				wgm_hi_q <= avs_writedata[WGM_HI_POS];
			end
			if (wr_hit(REG_ASYNC, avs_address, wr_stb, avs_byteenable[0])) begin
				async_q <= avs_writedata[ASYNC_POS]; // RULE_05
			end
			if (wr_hit(REG_POWER, avs_address, wr_stb, avs_byteenable[0])) begin
				pwr_gate_q <= avs_writedata[PWR_POS];
			end
			if (wr_hit(REG_IRQ_MASK, avs_address, wr_stb, avs_byteenable[0])) begin
				irq_mask_q <= avs_writedata[2:0];
			end
		end
	end

	// Each flag gated by its own mask bit onto the request line
	assign irq_request = |(irq_flag_q & irq_mask_q); // RULE_03

	// Tick generator connection; the power gate holds the tick generator idle
	assign tk.clock_select_field = cs_q; // RULE_06
	assign tk.async_clock_select = async_q;
	assign tk.run                = !pwr_gate_q; // RULE_02

	at8tc_tick_gen u_tick (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.osc_pin_in (osc_pin_in),
		.tk         (tk)
	);

	// Waveform generator: toggle in non-PWM, set/clear in PWM modes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_a_q <= 1'b0;
			out_b_q <= 1'b0;
		end else if (tk.timer_tick && !cnt_write) begin
			if (fp_mode) begin
				out_a_q <= match_a ? 1'b0 : (at_top ? 1'b1 : out_a_q); // RULE_15
				out_b_q <= match_b ? 1'b0 : (at_top ? 1'b1 : out_b_q); // RULE_15
			end else if (pc_mode) begin
				out_a_q <= match_a ? dir_down_q : out_a_q; // RULE_15
				out_b_q <= match_b ? dir_down_q : out_b_q; // RULE_15
			end else begin
				out_a_q <= out_a_q ^ match_a; // RULE_15
				out_b_q <= out_b_q ^ match_b; // RULE_15
			end
		end
	end

	assign compare_output_a = out_a_q;
	assign compare_output_b = out_b_q;
	// The crystal amplifier is analog; the digital core never drives it
	assign osc_pin_out = 1'b0;

	// Read data captured at the acknowledge edge; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avs_readdata_q <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			case (avs_address)
				REG_CTRL_A:   avs_readdata_q <= {30'h0, wgm_lo_q};
				REG_CTRL_B:   avs_readdata_q <= {28'h0, wgm_hi_q, cs_q};
				REG_COUNT:    avs_readdata_q <= {24'h0, counter_value_q}; // RULE_07
				REG_CMP_A:    avs_readdata_q <= {24'h0, cmp_buf_a_q};
				REG_CMP_B:    avs_readdata_q <= {24'h0, cmp_buf_b_q};
				REG_IRQ_MASK: avs_readdata_q <= {29'h0, irq_mask_q};
				REG_IRQ_FLAG: avs_readdata_q <= {29'h0, irq_flag_q}; // RULE_03
				REG_ASYNC:    avs_readdata_q <= {31'h0, async_q};
				REG_POWER:    avs_readdata_q <= {31'h0, pwr_gate_q};
				default:      avs_readdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign avs_readdata = avs_readdata_q;
endmodule // at8tc_core

// File: at8tc_core_props.sv
// Port-level checks for the 8-bit timer/counter core
`timescale 1ns/1ps
module at8tc_core_props
	import at8tc_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        osc_pin_in,
	input wire logic        osc_pin_out,
	input wire logic        compare_output_a,
	input wire logic        compare_output_b,
	input wire logic        irq_request
);
	default clocking cb @(posedge clk); endclocking
	// A request opens with a stall and closes one cycle later
	sequence s_req_open;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_req_done;
		(avs_read || avs_write) && !avs_waitrequest;
	endsequence
	a_one_wait: assert property (disable iff (sys_rst)
		$rose(avs_read || avs_write) |-> s_req_open ##1 s_req_done) else $error("no single wait");
	a_wait_ends: assert property (disable iff (sys_rst)
		s_req_open |=> !avs_waitrequest) else $error("stall lasted too long");
	a_stall_needs_req: assert property (
		avs_waitrequest |-> avs_read || avs_write) else $error("stall without request");
	a_read_lane: assert property (disable iff (sys_rst)
		s_req_done ##0 avs_read |-> avs_readdata[31:8] == 24'h000000) else $error("upper lanes set");
	// Read data only moves at the edge that ends a stalled read cycle
	a_read_hold: assert property (disable iff (sys_rst)
		!(avs_read && avs_waitrequest) |=> $stable(avs_readdata)) else $error("read data moved");
	a_reset_quiet: assert property (
		sys_rst |=> !irq_request && !compare_output_a && !compare_output_b
		&& avs_readdata == 32'h00000000) else $error("outputs not cleared by reset");
	// Masking everything must silence the request line at once
	a_mask_silences: assert property (disable iff (sys_rst)
		s_req_done ##0 (avs_write && avs_address == REG_IRQ_MASK && avs_byteenable[0]
		&& avs_writedata[2:0] == 3'h0) |=> !irq_request) else $error("irq despite mask");
	a_osc_out_low: assert property (
		osc_pin_out == 1'b0) else $error("oscillator output driven");
endmodule // at8tc_core_props

// File: test_at8tc_core.sv
// Register-level bench for the 8-bit timer/counter core
`timescale 1ns/1ps
module test_at8tc_core;
	import at8tc_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  adr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic        wait_q;
	logic        osc = 1'b0;
	logic        oca, ocb, irq, oca_d, ocb_d;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          tgl = 0;
	int          tglb = 0;
	int          t0;
	int          t1;
	logic [7:0]  v, p, mx;
	logic [2:0]  m;
	bit          desc;
	logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
	// Free-running 25 MHz clock
	always #20 clk = ~clk;
	at8tc_core dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'h1), .avs_readdata(rdat),
		.avs_waitrequest(wait_q), .osc_pin_in(osc), .osc_pin_out(), .compare_output_a(oca),
		.compare_output_b(ocb), .irq_request(irq));
	// Count output A and B changes to see the waveform unit move
	always @(posedge clk) begin
		oca_d <= oca;
		ocb_d <= ocb;
		if (oca !== oca_d) tgl <= tgl + 1;
		if (ocb !== ocb_d) tglb <= tglb + 1;
	end
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// One bus cycle; waitrequest and read data are both taken at the rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		n = 0;
		adr <= a;
		wdat <= {24'h000000, d};
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				error_cnt++;
				$display("[FAIL] %0t bus request never answered", $time);
				report_and_stop();
			end
		end while (wait_q !== 1'b0);
		r = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		// One idle edge keeps back-to-back requests apart
		@(posedge clk);
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d, v);
	endtask
	task automatic chk(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, v);
		cmp(v, e);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		// Reset values, then an unmapped index
		for (int i = 0; i < 10; i++) chk(4'(i), 8'h00);
		wreg(4'h9, 8'h5a);
		chk(4'h9, 8'h00);
		wreg(REG_POWER, 8'h00);
		wreg(REG_COUNT, 8'h33);
		repeat (20) @(posedge clk);
		chk(REG_COUNT, 8'h33);
		// Power gate set: a selected tick source must not move the counter
		wreg(REG_POWER, 8'h01);
		wreg(REG_CTRL_B, 8'h01);
		repeat (20) @(posedge clk);
		chk(REG_COUNT, 8'h33);
		wreg(REG_CTRL_B, 8'h00);
		wreg(REG_POWER, 8'h00);
		wreg(REG_CMP_A, 8'h0a);
		wreg(REG_CMP_B, 8'h04);
		chk(REG_CMP_A, 8'h0a);
		chk(REG_CMP_B, 8'h04);
		$display("test registers done");
		// Each mode: bounded by top, dual slope or not, which flags rise
		foreach (modes[k]) begin
			m = modes[k];
			wreg(REG_CTRL_B, 8'h00);
			wreg(REG_COUNT, 8'h00);
			wreg(REG_IRQ_FLAG, 8'h07);
			wreg(REG_CTRL_A, {6'h00, m[1:0]});
			t0 = tgl;
			t1 = tglb;
			mx = 8'h00;
			p = 8'h00;
			desc = 1'b0;
			wreg(REG_CTRL_B, {4'h0, m[2], 3'h1});
			for (int i = 0; i < 200; i++) begin
				bus(1'b0, REG_COUNT, 8'h00, v);
				if (v > mx) mx = v;
				if (v < p && p - v <= 8'h04) desc = 1'b1;
				p = v;
			end
			wreg(REG_CTRL_B, 8'h00);
			cmp(8'(mx <= 8'h0a), 8'(m inside {3'h2, 3'h5, 3'h7}));
			cmp(8'(desc), 8'(m == 3'h1 || m == 3'h5));
			chk(REG_IRQ_FLAG, {5'h00, 2'h3, m != 3'h2});
			if (m == 3'h2) cmp(8'(tgl != t0), 8'h01);
			if (m == 3'h2) cmp(8'(tglb != t1), 8'h01);
			$display("test mode %0d done", m);
		end
		// Running counter: write wins, overflow raises a masked request
		wreg(REG_CTRL_A, 8'h00);
		wreg(REG_IRQ_FLAG, 8'h07);
		wreg(REG_IRQ_MASK, 8'h01);
		wreg(REG_CTRL_B, 8'h01);
		wreg(REG_COUNT, 8'hf0);
		bus(1'b0, REG_COUNT, 8'h00, v);
		cmp(8'(v - 8'hf0 < 8'h05), 8'h01);
		for (int n = 0; irq !== 1'b1; n++) begin
			if (n == 60) begin
				error_cnt++;
				$display("[FAIL] %0t overflow request never came", $time);
				report_and_stop();
			end
			@(posedge clk);
		end
		cmp(8'(irq), 8'h01);
		wreg(REG_CTRL_B, 8'h00);
		wreg(REG_IRQ_MASK, 8'h00);
		cmp(8'(irq), 8'h00);
		wreg(REG_IRQ_FLAG, 8'h07);
		chk(REG_IRQ_FLAG, 8'h00);
		$display("test irq done");
		// Oscillator pin as tick source, five rising edges
		wreg(REG_ASYNC, 8'h01);
		wreg(REG_COUNT, 8'h00);
		wreg(REG_CTRL_B, 8'h01);
		repeat (5) begin
			repeat (4) @(posedge clk);
			osc <= 1'b1;
			repeat (4) @(posedge clk);
			osc <= 1'b0;
		end
		repeat (6) @(posedge clk);
		chk(REG_COUNT, 8'h05);
		$display("test async done");
		report_and_stop();
	end
endmodule // test_at8tc_core
bind at8tc_core at8tc_core_props chk_u (.clk(clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out), .compare_output_a(compare_output_a),
	.compare_output_b(compare_output_b), .irq_request(irq_request));
